// File: design/slcc_rate_detect.sv
// Encode-rate detector: flags when encode edges are spaced too far apart.
// Assumes encode_i is synchronous to clk_i.
`default_nettype none
module slcc_rate_detect (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Control and status
    input wire logic enable_i,
    input wire logic encode_i,
    output logic low_rate_o
);
    logic [slcc_pkg::RATE_W-1:0] cnt_reg;
    logic enc_d_reg;
    wire rise = encode_i & ~enc_d_reg;
    wire at_limit = cnt_reg >= slcc_pkg::RATE_W'(slcc_pkg::LOW_RATE_CYCLES);
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
            enc_d_reg <= 1'b0;
            low_rate_o <= 1'b0;
        end else begin
            enc_d_reg <= encode_i;
            if (!enable_i || rise) begin
                cnt_reg <= '0;
            end else if (!at_limit) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            // Low rate when no encode edge arrives within the limit.
            // An encode edge always ends the low-rate state, even one that
            // lands on the limit cycle, so the flag cannot latch on.
            low_rate_o <= enable_i & ~rise & (at_limit | low_rate_o);
        end
    end

    rise_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        enable_i && rise |=> !low_rate_o)
        else $error("low rate kept after an encode edge");
    det_limit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        enable_i && at_limit && !rise |=> low_rate_o)
        else $error("low rate not flagged at the limit");
    det_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !enable_i |=> !low_rate_o && cnt_reg == '0)
        else $error("disabled detector still active");
endmodule : slcc_rate_detect
`default_nettype wire

// File: design/slcc_top.sv
// Sync control and low-rate clock control registers of a dual converter.
// Assumes the serial port delivers one-cycle write strobes on clk_i.
// Contract
// - No sync action without master enable
// - Divider sync needs bit 1 and master
// - Next-only low: sync every pulse
// - Next-only high: first pulse only
// - Divider sync enable clears after sync in next-only mode
// - Output enable pin honoured only when enabled
// - Detector starts oscillator below low rate
// - Run bit forces oscillator on
// - Bit 0 disconnects serial data pull-down
`default_nettype none
module slcc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register write port and read data
    input wire logic reg_wr_i,
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Sync and clock divider
    input wire logic sync_i,
    input wire logic [2:0] div_ratio_i,
    output logic div_tick_o,
    output logic div_synced_o,
    // Output enable pin
    input wire logic output_enable_pin_i,
    output logic data_out_en_o,
    // Low-rate oscillator and serial data pin
    input wire logic encode_i,
    output logic low_rate_internal_oscillator_o,
    output logic serial_pulldown_en_o
);
    slcc_pkg::slcc_wr_s wr;
    logic [7:0] sync_control_reg;
    logic [7:0] user_config_two_reg;
    logic [7:0] rdata_next;
    logic [slcc_pkg::DIV_W-1:0] phase_reg;
    logic sync_d_reg;
    logic low_rate;

    assign wr = '{wr: reg_wr_i, addr: reg_addr_i, data: reg_wdata_i};
    wire wr_sync = wr.wr && wr.addr == slcc_pkg::SYNC_CTRL_ADDR;
    wire wr_cfg = wr.wr && wr.addr == slcc_pkg::USER_CFG2_ADDR;
    wire master_en = sync_control_reg[slcc_pkg::SYNC_MASTER_BIT];
    wire div_en = sync_control_reg[slcc_pkg::SYNC_DIV_EN_BIT];
    wire next_only = sync_control_reg[slcc_pkg::SYNC_NEXT_ONLY_BIT];
    wire sync_rise = sync_i & ~sync_d_reg;
    wire sync_accept = sync_rise & master_en & div_en;
    wire phase_end = phase_reg >= div_ratio_i;

    assign rdata_next = (reg_addr_i == slcc_pkg::SYNC_CTRL_ADDR) ?
        {5'h00, sync_control_reg[2:0]} :
        (reg_addr_i == slcc_pkg::USER_CFG2_ADDR) ?
        {user_config_two_reg[7], 3'h0, user_config_two_reg[3:2], 1'b0,
         user_config_two_reg[0]} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sync_control_reg <= slcc_pkg::SYNC_CTRL_RESET;
        end else if (sync_accept && next_only) begin
            // Hardware clear wins over a same-cycle write of bit 1.
            sync_control_reg <= (wr_sync ? wr.data : sync_control_reg) &
                ~(8'h01 << slcc_pkg::SYNC_DIV_EN_BIT);
        end else if (wr_sync) begin
            sync_control_reg <= wr.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            user_config_two_reg <= slcc_pkg::USER_CFG2_RESET;
        end else if (wr_cfg) begin
            user_config_two_reg <= wr.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sync_d_reg <= 1'b0;
            phase_reg <= '0;
            div_tick_o <= 1'b0;
            div_synced_o <= 1'b0;
        end else begin
            sync_d_reg <= sync_i;
            div_synced_o <= sync_accept;
            if (sync_accept || phase_end) begin
                phase_reg <= '0;
            end else begin
                phase_reg <= phase_reg + 1'b1;
            end
            div_tick_o <= sync_accept | phase_end;
        end
    end

    slcc_rate_detect u_rate (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(user_config_two_reg[slcc_pkg::CFG_DETECT_EN_BIT]),
        .encode_i(encode_i),
        .low_rate_o(low_rate)
    );

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
            data_out_en_o <= 1'b1;
            low_rate_internal_oscillator_o <= 1'b0;
            serial_pulldown_en_o <= 1'b1;
        end else begin
            reg_rdata_o <= rdata_next;
            // Pin is active low; ignored when the enable bit is clear.
            data_out_en_o <= ~(user_config_two_reg[slcc_pkg::CFG_OE_PIN_EN_BIT]
                & output_enable_pin_i);
            low_rate_internal_oscillator_o <= low_rate |
                user_config_two_reg[slcc_pkg::CFG_RUN_OSC_BIT];
            serial_pulldown_en_o <=
                ~user_config_two_reg[slcc_pkg::CFG_PULLDOWN_OFF_BIT];
        end
    end

    sync_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(sync_i) && !(master_en && div_en) |=> !div_synced_o)
        else $error("sync accepted while disabled");
    sync_take_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(sync_i) && master_en && div_en |=> div_synced_o)
        else $error("enabled sync pulse missed");
    cont_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sync_accept && !next_only && !wr_sync |=> div_en)
        else $error("continuous mode lost enable");
    once_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sync_accept && next_only |=> !div_en)
        else $error("next-only did not clear enable");
    phase_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sync_accept |=> phase_reg == '0 && div_tick_o)
        else $error("divider phase not reset");
    oe_ignore_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !user_config_two_reg[7] && !$past(wr_cfg) |=> data_out_en_o)
        else $error("disabled pin blocked outputs");
    osc_force_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        user_config_two_reg[2] |=> low_rate_internal_oscillator_o)
        else $error("run bit did not start oscillator");
    pull_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        user_config_two_reg[0] |=> !serial_pulldown_en_o)
        else $error("pull-down not disconnected");
    // Detector and run bit both clear; two such cycles flush the detector.
    sequence s_osc_idle;
        !user_config_two_reg[3] && !user_config_two_reg[2];
    endsequence
    sequence s_osc_idle_twice;
        s_osc_idle ##1 s_osc_idle;
    endsequence
    det_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_osc_idle_twice |=> !low_rate_internal_oscillator_o)
        else $error("oscillator on with detector off");
    det_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        low_rate |=> low_rate_internal_oscillator_o)
        else $error("low rate did not start oscillator");
    osc_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !low_rate && !user_config_two_reg[2] |=>
        !low_rate_internal_oscillator_o)
        else $error("oscillator on with no cause");
    oe_honour_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        user_config_two_reg[7] && output_enable_pin_i |=> !data_out_en_o)
        else $error("enabled pin did not disable outputs");
    oe_pass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        user_config_two_reg[7] && !output_enable_pin_i |=> data_out_en_o)
        else $error("outputs off with pin released");
    pull_on_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !user_config_two_reg[0] |=> serial_pulldown_en_o)
        else $error("pull-down removed while bit clear");
    // Divider wrap without a sync pulse: tick and restart of the phase.
    sequence s_free_wrap;
        phase_end && !sync_accept;
    endsequence
    div_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_free_wrap |=> div_tick_o && phase_reg == '0)
        else $error("divider did not wrap");
    div_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !phase_end && !sync_accept |=> !div_tick_o && !div_synced_o)
        else $error("divider tick without cause");
    master_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !master_en |=> !div_synced_o)
        else $error("sync action with master enable clear");
    rd_unmapped_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        reg_addr_i != slcc_pkg::SYNC_CTRL_ADDR &&
        reg_addr_i != slcc_pkg::USER_CFG2_ADDR |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule : slcc_top
`default_nettype wire

// File: inc/slcc_pkg.sv
// Package for the sync and low-rate clock control block.
// Assumes a register write port in the sample clock domain.
`default_nettype none
package slcc_pkg;
    localparam logic [8:0] SYNC_CTRL_ADDR = 9'h100;
    localparam logic [8:0] USER_CFG2_ADDR = 9'h101;
    localparam logic [7:0] SYNC_CTRL_RESET = 8'h01;
    localparam logic [7:0] USER_CFG2_RESET = 8'h88;
    localparam int SYNC_MASTER_BIT = 0;
    localparam int SYNC_DIV_EN_BIT = 1;
    localparam int SYNC_NEXT_ONLY_BIT = 2;
    localparam int CFG_PULLDOWN_OFF_BIT = 0;
    localparam int CFG_RUN_OSC_BIT = 2;
    localparam int CFG_DETECT_EN_BIT = 3;
    localparam int CFG_OE_PIN_EN_BIT = 7;
    // Sample clock runs at 100 MHz; low rate means encode below 5 MSPS.
    localparam int CLK_MHZ = 100;
    localparam int LOW_RATE_MSPS = 5;
    localparam int LOW_RATE_CYCLES = CLK_MHZ / LOW_RATE_MSPS;
    localparam int DIV_W = 3;
    localparam int RATE_W = 6;
    typedef struct packed {
        logic wr;
        logic [8:0] addr;
        logic [7:0] data;
    } slcc_wr_s;
endpackage : slcc_pkg
`default_nettype wire

// File: testbench/slcc_host.sv
// Host model on the register port: register writes and reads.
// Assumes a free-running clk_i; drives 1 ns after each rising edge.
`default_nettype none
module slcc_host (
    // Clock and read data
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    // Write strobe, address and data
    output var slcc_pkg::slcc_wr_s bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus_o = '0;
    task automatic write(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 bus_o = '{wr: 1'b1, addr: a, data: d};
        @(posedge clk_i);
        // Only the strobe drops, so the port stays quiet between writes.
        #1 bus_o.wr = 1'b0;
    endtask : write
    task automatic read(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 bus_o.addr = a;
        repeat (2) @(posedge clk_i);
        #1 d = rdata_i;
    endtask : read
endmodule : slcc_host
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the sync and low-rate clock control block.
// Assumes the host model in slcc_host and the package slcc_pkg.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sync_i = 1'b0;
    logic oe_pin = 1'b0;
    logic encode = 1'b0;
    logic enc_run = 1'b1;
    logic [2:0] div_ratio = 3'h7;
    logic [7:0] rdata;
    logic [7:0] rd;
    logic tick, synced, out_en, osc, pd_en;
    slcc_pkg::slcc_wr_s bus;
    int miscompares = 0;
    int samples_checked = 0;
    slcc_host host (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));
    slcc_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(bus.wr),
        .reg_addr_i(bus.addr), .reg_wdata_i(bus.data), .reg_rdata_o(rdata),
        .sync_i(sync_i), .div_ratio_i(div_ratio), .div_tick_o(tick),
        .div_synced_o(synced), .output_enable_pin_i(oe_pin),
        .data_out_en_o(out_en), .encode_i(encode),
        .low_rate_internal_oscillator_o(osc), .serial_pulldown_en_o(pd_en));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) encode <= enc_run & ~encode;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
        host.read(a, rd);
        chk(rd, exp);
    endtask : rchk
    // Counts cycles showing both the synced output and a divider tick.
    task automatic pulse(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        @(posedge clk_i);
        #1 sync_i = 1'b1;
        repeat (3) begin
            @(posedge clk_i);
            #1 sync_i = 1'b0;
            if (synced === 1'b1 && tick === 1'b1) n = n + 8'h01;
        end
        chk(n, exp);
    endtask : pulse
    // Checks output enable, oscillator and pull-down after settling.
    task automatic look(input logic [2:0] exp);
        repeat (3) @(posedge clk_i);
        #1 chk({5'h00, out_en, osc, pd_en}, {5'h00, exp});
    endtask : look
    task automatic t_reset;
        rchk(9'h100, 8'h01);
        rchk(9'h101, 8'h88);
        rchk(9'h0FF, 8'h00);
        look(3'h5);
        pulse(8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_sync;
        host.write(9'h100, 8'h02);
        pulse(8'h00);
        host.write(9'h100, 8'h03);
        pulse(8'h01);
        @(posedge clk_i);
        #1 div_ratio = 3'h3;
        pulse(8'h01);
        host.write(9'h100, 8'h07);
        pulse(8'h01);
        rchk(9'h100, 8'h05);
        pulse(8'h00);
        $display("sync test done");
    endtask : t_sync
    task automatic t_cfg;
        @(posedge clk_i);
        #1 oe_pin = 1'b1;
        host.write(9'h101, 8'h88);
        look(3'h1);
        host.write(9'h101, 8'h08);
        look(3'h5);
        host.write(9'h101, 8'h09);
        look(3'h4);
        host.write(9'h101, 8'h0C);
        look(3'h7);
        host.write(9'h101, 8'h08);
        look(3'h5);
        enc_run = 1'b0;
        repeat (25) @(posedge clk_i);
        look(3'h7);
        enc_run = 1'b1;
        look(3'h5);
        host.write(9'h101, 8'h00);
        enc_run = 1'b0;
        repeat (25) @(posedge clk_i);
        look(3'h5);
        $display("config test done");
    endtask : t_cfg
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        t_reset();
        t_sync();
        t_cfg();
        results();
    end
endmodule : tb
`default_nettype wire
